/* File: logic/smpd_pkg.sv */
package smpd_pkg;

  // register map, byte addresses on the management bus
  localparam logic [7:0] ADDR_QUIESCENT_MODE_CONFIG   = 8'h1a;
  localparam logic [7:0] ADDR_RAIL_ENABLE_CONTROL     = 8'h2f;
  localparam logic [7:0] ADDR_REGULATOR_ENABLE_CONTROL = 8'h32;
  localparam logic [7:0] ADDR_POWER_OFF_SEQUENCE_STEP0 = 8'h58;
  localparam logic [7:0] ADDR_POWER_OFF_SEQUENCE_STEP1 = 8'h59;
  localparam logic [7:0] ADDR_POWER_OFF_SEQUENCE_STEP2 = 8'h5a;

  // field positions
  localparam int QUIESCENT_ENABLE_POS = 4;
  localparam int REG_ENABLE_POS       = 7;
  localparam int PG_AS_INPUT_POS      = 5;
  localparam int RAIL_A_POS           = 6;
  localparam int RAIL_B_POS           = 4;
  localparam int RAIL_C_POS           = 3;
  localparam int STEP_DELAY_LSB       = 4;

  // reset values
  localparam logic [7:0] RST_QUIESCENT_CONFIG = 8'h00;
  localparam logic [7:0] RST_RAIL_ENABLE      = 8'h58;
  localparam logic [7:0] RST_REG_ENABLE       = 8'h00;
  localparam logic [7:0] RST_STEP0            = 8'h11;
  localparam logic [7:0] RST_STEP1            = 8'h12;
  localparam logic [7:0] RST_STEP2            = 8'h14;
  localparam logic [2:0] RAILS_NONE           = 3'h0;

  // event sources, one bit each
  localparam int NUM_EVENTS = 12;
  localparam logic [11:0] EVT_PG_LOW_SET  = 12'h0_23f;
  localparam logic [11:0] EVT_VR_DISABLE  = 12'h0_21a;
  localparam logic [11:0] EVT_CLEARABLE   = 12'h0_dff;

  // timing, clock 20 MHz
  localparam int CLK_PERIOD_NS      = 50;
  localparam int SOFT_STOP_A_NS     = 1000;
  localparam int SOFT_STOP_B_NS     = 2000;
  localparam int SOFT_STOP_C_NS     = 500;
  localparam int DELAY_UNIT_NS      = 2000;
  localparam int PG_RELEASE_DELAY_NS = 5000;

  // least time rounded up to whole cycles, never below one
  function automatic logic [15:0] ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) c = 1;
    return c[15:0];
  endfunction : ns_to_cycles

  localparam logic [15:0] SOFT_STOP_A_CYC = ns_to_cycles(SOFT_STOP_A_NS);
  localparam logic [15:0] SOFT_STOP_B_CYC = ns_to_cycles(SOFT_STOP_B_NS);
  localparam logic [15:0] SOFT_STOP_C_CYC = ns_to_cycles(SOFT_STOP_C_NS);
  localparam logic [15:0] DELAY_UNIT_CYC  = ns_to_cycles(DELAY_UNIT_NS);
  localparam logic [15:0] PG_RELEASE_CYC  = ns_to_cycles(PG_RELEASE_DELAY_NS);

  // high level power state, gray along the usual path
  typedef enum logic [3:0] {
    ST_INVALID_INPUT   = 4'h0,
    ST_PRE_ENABLE      = 4'h1,
    ST_ON_SEQ          = 4'h3,
    ST_REGULATION      = 4'h2,
    ST_OFF_SEQ         = 4'h6,
    ST_PIN_OFF         = 4'h7,
    ST_QUIESCENT       = 4'h5,
    ST_PG_OFF          = 4'h4,
    ST_FAULT_OFF       = 4'hc
  } smpd_state_type;

  typedef enum logic [1:0] {
    CAUSE_PIN   = 2'h0,
    CAUSE_PG_IN = 2'h1,
    CAUSE_FAULT = 2'h3
  } smpd_cause_type;

  // decoded register access from the bus front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } smpd_bus_req_type;

endpackage : smpd_pkg

/* File: logic/smpd_ctrl.sv */
`timescale 1ns/1ps
//
// Overview of operation
// - secure pin fall: pull power-good, run off steps
// - pin rise restarts on steps, releases power-good
// - secure mode ignores bus enable bit writes
// - secure mode: zero writes to rail bits ignored
// - power-good input low: off steps, unlock enable
// - keep registers, keep others locked meanwhile
// - bus enable restarts, releases power-good, relocks
// - internal fault: off steps, power-good low
// - after fault ignore all enables, hold low
// - quiescent enable: pin disable enters quiescent
// - fault shutdown never enters quiescent
// - step waits longest soft-stop then delays
// - interrupt open-drain, active low, latched
// - interrupt holds until condition gone, cleared
// - status bits latch until one written clear; bit 9 clears only on reset
// - clear while condition persists re-raises
// - interrupt does not change regulator operation
// - twelve listed interrupt event sources
// - quiescent: all regulators off, no bus
// - idle: regulators on, bus allowed
// - pre-enable: switchers off, ldo on, pg low
// - fault off state; regulation sets enable bit
// - mask gates only interrupt and power-good
module smpd_ctrl
  import smpd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              secure_mode,
  input  wire logic              bulk_input_supply_valid,
  input  wire logic              regulator_enable_pin,
  input  wire logic              power_good_pin_in,
  output logic                   power_good_pin_out,
  output logic                   power_good_pin_oe,
  output logic                   general_status_irq_n_out,
  output logic                   general_status_irq_n_oe,
  input  wire logic [11:0]       event_cond,
  input  wire logic [11:0]       event_mask,
  input  wire logic [11:0]       event_clear,
  output logic [11:0]            event_status,
  input  wire smpd_bus_req_type  bus_req,
  output logic [7:0]             bus_rdata,
  output logic                   bus_access_ok,
  output logic [2:0]             rail_on,
  output logic                   ldo_on,
  output smpd_state_type         power_state
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, two flops before any logic reads them

  logic [1:0] en_sync_r;
  logic [1:0] pg_sync_r;
  logic [1:0] bulk_sync_r;
  logic [1:0] pg_own_r;
  logic       en_prev_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      en_sync_r   <= 2'h0;
      pg_sync_r   <= 2'h3;
      bulk_sync_r <= 2'h0;
      en_prev_r   <= 1'b0;
      pg_own_r    <= 2'h3;
    end else begin
      en_sync_r   <= {en_sync_r[0], regulator_enable_pin};
      pg_sync_r   <= {pg_sync_r[0], power_good_pin_in};
      bulk_sync_r <= {bulk_sync_r[0], bulk_input_supply_valid};
      en_prev_r   <= en_sync_r[1];
      pg_own_r    <= {pg_own_r[0], power_good_pin_oe}; // own pull echoes through pg_sync_r
    end
  end

  wire pin_en   = en_sync_r[1];
  wire pin_fall = en_prev_r & ~pin_en;
  wire pin_rise = ~en_prev_r & pin_en;
  wire bulk_ok  = bulk_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic [7:0]     qcfg_r;
  logic [7:0]     rail_en_r;
  logic [7:0]     reg_en_r;
  logic [7:0]     step_r [3];
  logic           unlock_r;
  smpd_state_type state_r;
  smpd_state_type state_nxt;

  // quiescent state refuses the bus entirely
  assign bus_access_ok = (state_r != ST_QUIESCENT) && (state_r != ST_INVALID_INPUT);

  wire bus_wr   = bus_req.wr & bus_access_ok;
  wire wr_qcfg  = bus_wr && (bus_req.addr == ADDR_QUIESCENT_MODE_CONFIG);
  wire wr_rail  = bus_wr && (bus_req.addr == ADDR_RAIL_ENABLE_CONTROL);
  wire wr_ren   = bus_wr && (bus_req.addr == ADDR_REGULATOR_ENABLE_CONTROL);
  wire wr_step0 = bus_wr && (bus_req.addr == ADDR_POWER_OFF_SEQUENCE_STEP0);
  wire wr_step1 = bus_wr && (bus_req.addr == ADDR_POWER_OFF_SEQUENCE_STEP1);
  wire wr_step2 = bus_wr && (bus_req.addr == ADDR_POWER_OFF_SEQUENCE_STEP2);

  wire q_en    = qcfg_r[QUIESCENT_ENABLE_POS];
  wire pg_as_in = reg_en_r[PG_AS_INPUT_POS];

  // in secure mode the enable bit is locked unless the pg-input shutdown opened it
  wire ren_bit_wr_ok = ~secure_mode | unlock_r;
  wire bus_enable_cmd = wr_ren & bus_req.wdata[REG_ENABLE_POS] & ren_bit_wr_ok;

  // rail bits: secure mode lets software set them but never clear them
  localparam logic [7:0] RAIL_FIELD = 8'(1 << RAIL_A_POS | 1 << RAIL_B_POS | 1 << RAIL_C_POS);
  wire [7:0] rail_wr_val = secure_mode ? (rail_en_r | (bus_req.wdata & RAIL_FIELD))
                                       : ((rail_en_r & ~RAIL_FIELD) | (bus_req.wdata & RAIL_FIELD));

  // enable bit is owned by the sequencer; control bits follow the bus
  wire [7:0] ren_ctl_val = wr_ren ? (bus_req.wdata & ~(8'h01 << REG_ENABLE_POS))
                                  : (reg_en_r & ~(8'h01 << REG_ENABLE_POS));
  wire       ren_bit_nxt = (state_nxt == ST_REGULATION) || (state_nxt == ST_ON_SEQ);
  wire [7:0] reg_en_nxt  = ren_ctl_val | ({7'h00, ren_bit_nxt} << REG_ENABLE_POS);

  // config registers; contents survive every shutdown path
  always_ff @(posedge clk) begin
    if (rst) begin
      qcfg_r    <= RST_QUIESCENT_CONFIG;
      rail_en_r <= RST_RAIL_ENABLE;
      reg_en_r  <= RST_REG_ENABLE;
      step_r[0] <= RST_STEP0;
      step_r[1] <= RST_STEP1;
      step_r[2] <= RST_STEP2;
    end else begin
      if (wr_qcfg && !secure_mode) qcfg_r <= bus_req.wdata;
      if (wr_rail) rail_en_r <= rail_wr_val;
      reg_en_r <= reg_en_nxt;
      if (wr_step0 && !secure_mode) step_r[0] <= bus_req.wdata;
      if (wr_step1 && !secure_mode) step_r[1] <= bus_req.wdata;
      if (wr_step2 && !secure_mode) step_r[2] <= bus_req.wdata;
    end
  end

  // read mux, registered so the data output comes from a flop
  wire [7:0] rd_mux =
    (bus_req.addr == ADDR_QUIESCENT_MODE_CONFIG)    ? qcfg_r    :
    (bus_req.addr == ADDR_RAIL_ENABLE_CONTROL)      ? rail_en_r :
    (bus_req.addr == ADDR_REGULATOR_ENABLE_CONTROL) ? reg_en_r  :
    (bus_req.addr == ADDR_POWER_OFF_SEQUENCE_STEP0) ? step_r[0] :
    (bus_req.addr == ADDR_POWER_OFF_SEQUENCE_STEP1) ? step_r[1] :
    (bus_req.addr == ADDR_POWER_OFF_SEQUENCE_STEP2) ? step_r[2] : 8'h00;

  always_ff @(posedge clk) begin
    if (rst) bus_rdata <= 8'h00;
    else if (bus_req.rd) bus_rdata <= bus_access_ok ? rd_mux : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // event status and interrupt

  logic [11:0] status_r;
  // set wins over clear, so a persisting condition re-latches at once
  wire [11:0] status_nxt = (status_r & ~(event_clear & EVT_CLEARABLE)) | event_cond;
  wire [11:0] live       = status_r & ~event_mask;
  wire        irq_active = |live;
  wire        pg_evt_low = |(live & EVT_PG_LOW_SET);
  // fault shutdown ignores the mask: only the pins are gated by it
  wire        fault_trig = |(event_cond & EVT_VR_DISABLE);

  always_ff @(posedge clk) begin
    if (rst) status_r <= 12'h000;
    else status_r <= status_nxt;
  end

  assign event_status = status_r;

  // open-drain pins: output level fixed low, enable pulls the wire
  assign general_status_irq_n_out = 1'b0;
  assign general_status_irq_n_oe  = irq_active;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: state, step index, timer, rails

  smpd_cause_type cause_r;
  logic [1:0]     step_idx_r;
  logic           in_delay_r;
  logic [15:0]    timer_r;
  logic [2:0]     seq_rail_r;
  logic           pg_hold_r;

  // longest soft-stop among the rails of one step
  function automatic logic [15:0] longest_stop(input logic [2:0] m);
    logic [15:0] t;
    t = 16'h0001;
    if (m[2] && SOFT_STOP_A_CYC > t) t = SOFT_STOP_A_CYC;
    if (m[1] && SOFT_STOP_B_CYC > t) t = SOFT_STOP_B_CYC;
    if (m[0] && SOFT_STOP_C_CYC > t) t = SOFT_STOP_C_CYC;
    return t;
  endfunction : longest_stop

  function automatic logic [15:0] step_delay(input logic [7:0] s);
    return 16'(s[STEP_DELAY_LSB +: 2]) * DELAY_UNIT_CYC;
  endfunction : step_delay

  wire        timer_done = (timer_r == 16'h0000);
  wire        last_step  = (step_idx_r == 2'h2);
  wire        in_reg     = (state_r == ST_REGULATION) || (state_r == ST_ON_SEQ);

  // shutdown requests, priority fault > pg input > pin
  wire pg_trig  = secure_mode && pg_as_in && !pg_sync_r[1] && (state_r == ST_REGULATION)
                  && !power_good_pin_oe && !(|pg_own_r);
  wire pin_trig = secure_mode && pin_fall && in_reg;
  wire start_off = (fault_trig && in_reg) || pg_trig || pin_trig;
  smpd_cause_type new_cause;
  assign new_cause = fault_trig ? CAUSE_FAULT : (pg_trig ? CAUSE_PG_IN : CAUSE_PIN);

  // on-sequence requests: pin in pre-enable/pin-off/quiescent, bus after pg-input
  wire start_on_pin = pin_rise && ((state_r == ST_PRE_ENABLE) || (state_r == ST_PIN_OFF)
                      || (state_r == ST_QUIESCENT));
  wire start_on_bus = bus_enable_cmd && ((state_r == ST_PG_OFF) ||
                      (!secure_mode && (state_r == ST_PRE_ENABLE)));

  // next state; fault off only leaves through reset, the power cycle
  always_comb begin
    state_nxt = state_r;
    if (!bulk_ok && state_r != ST_FAULT_OFF) begin
      state_nxt = ST_INVALID_INPUT;
    end else begin
      case (state_r)
        ST_INVALID_INPUT: state_nxt = ST_PRE_ENABLE;
        ST_PRE_ENABLE,
        ST_PIN_OFF,
        ST_QUIESCENT: if (start_on_pin) state_nxt = ST_ON_SEQ;
        ST_PG_OFF: if (start_on_bus) state_nxt = ST_ON_SEQ;
        ST_ON_SEQ,
        ST_REGULATION: if (start_off) state_nxt = ST_OFF_SEQ;
        ST_OFF_SEQ: begin
          if (fault_trig && cause_r != CAUSE_FAULT) state_nxt = ST_OFF_SEQ;
          else if (in_delay_r && timer_done && last_step) begin
            if (cause_r == CAUSE_FAULT) state_nxt = ST_FAULT_OFF;
            else if (cause_r == CAUSE_PG_IN) state_nxt = ST_PG_OFF;
            else if (q_en) state_nxt = ST_QUIESCENT;
            else state_nxt = ST_PIN_OFF;
          end
        end
        ST_FAULT_OFF: state_nxt = ST_FAULT_OFF;
        default: state_nxt = ST_INVALID_INPUT;
      endcase
      if (state_r == ST_ON_SEQ && !start_off && in_delay_r && timer_done
          && last_step && !pg_hold_r) state_nxt = ST_REGULATION;
    end
  end

  wire entering_off = (state_nxt == ST_OFF_SEQ) && (state_r != ST_OFF_SEQ);
  wire entering_on  = (state_nxt == ST_ON_SEQ) && (state_r != ST_ON_SEQ);
  wire seq_active   = (state_r == ST_OFF_SEQ) || (state_r == ST_ON_SEQ);
  wire step_adv     = seq_active && in_delay_r && timer_done && !last_step;
  wire to_delay     = seq_active && !in_delay_r && timer_done;

  // step: rails change, wait longest soft-stop, then the programmed delay
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r    <= ST_INVALID_INPUT;
      cause_r    <= CAUSE_PIN;
      step_idx_r <= 2'h0;
      in_delay_r <= 1'b0;
      timer_r    <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      if (entering_off || (state_r == ST_OFF_SEQ && fault_trig && cause_r != CAUSE_FAULT))
        cause_r <= entering_off ? new_cause : CAUSE_FAULT;
      if (entering_off || entering_on) begin
        step_idx_r <= 2'h0;
        in_delay_r <= 1'b0;
        timer_r    <= longest_stop(step_r[0][2:0]) - 16'h0001;
      end else if (to_delay) begin
        in_delay_r <= 1'b1;
        timer_r    <= step_delay(step_r[step_idx_r]);
      end else if (step_adv) begin
        step_idx_r <= step_idx_r + 2'h1;
        in_delay_r <= 1'b0;
        timer_r    <= longest_stop(step_r[step_idx_r + 2'h1][2:0]) - 16'h0001;
      end else if (!timer_done) begin
        timer_r <= timer_r - 16'h0001;
      end
    end
  end

  // rails driven by the sequencer, then gated by the rail enable bits
  wire [2:0] step_mask_now = (entering_off || entering_on) ? step_r[0][2:0]
                             : step_r[step_idx_r + 2'h1][2:0];
  wire       step_load     = entering_off || entering_on || step_adv;
  wire       going_on      = entering_on || (state_r == ST_ON_SEQ && !entering_off);

  always_ff @(posedge clk) begin
    if (rst) seq_rail_r <= RAILS_NONE;
    else if (state_nxt == ST_INVALID_INPUT || state_nxt == ST_QUIESCENT) seq_rail_r <= RAILS_NONE;
    else if (step_load && going_on) seq_rail_r <= seq_rail_r | step_mask_now;
    else if (step_load) seq_rail_r <= seq_rail_r & ~step_mask_now;
  end

  assign rail_on = seq_rail_r & {rail_en_r[RAIL_A_POS], rail_en_r[RAIL_B_POS],
                                 rail_en_r[RAIL_C_POS]};
  assign ldo_on  = (state_r != ST_QUIESCENT) && (state_r != ST_INVALID_INPUT);
  assign power_state = state_r;

  ////////////////////////////////////////////////////////////////////////////
  // power-good release delay and pg-input unlock

  logic [15:0] pg_cnt_r;
  wire last_on_delay_done = (state_r == ST_ON_SEQ) && in_delay_r && timer_done && last_step;

  // pull power-good low from the start of a shutdown until release delay ends
  always_ff @(posedge clk) begin
    if (rst) begin
      pg_hold_r <= 1'b1;
      pg_cnt_r  <= 16'h0000;
    end else if (state_nxt != ST_ON_SEQ && state_nxt != ST_REGULATION) begin
      pg_hold_r <= 1'b1;
      pg_cnt_r  <= 16'h0000;
    end else if (last_on_delay_done && pg_hold_r) begin
      if (pg_cnt_r == PG_RELEASE_CYC - 16'h0001) pg_hold_r <= 1'b0;
      else pg_cnt_r <= pg_cnt_r + 16'h0001;
    end
  end

  // only the enable bit opens during pg-input shutdown; closes on re-enable
  always_ff @(posedge clk) begin
    if (rst) unlock_r <= 1'b0;
    else if (entering_off && new_cause == CAUSE_PG_IN) unlock_r <= 1'b1;
    else if (entering_on || state_nxt == ST_FAULT_OFF) unlock_r <= 1'b0;
  end

  assign power_good_pin_out = 1'b0;
  assign power_good_pin_oe  = pg_hold_r || pg_evt_low;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_pin_off;
    (state_r == ST_REGULATION) && pin_trig && !fault_trig |=>
      (state_r == ST_OFF_SEQ) && power_good_pin_oe && (cause_r == CAUSE_PIN);
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin fall did not start shutdown");

  property p_bus_lock;
    secure_mode && !unlock_r && (state_r == ST_REGULATION) && !start_off |=>
      reg_en_r[REG_ENABLE_POS];
  endproperty
  a_bus_lock: assert property (p_bus_lock) else $error("locked enable bit changed");

  property p_rail_keep;
    secure_mode && wr_rail |=> ((rail_en_r & $past(rail_en_r)) == $past(rail_en_r));
  endproperty
  a_rail_keep: assert property (p_rail_keep) else $error("secure rail bit cleared");

  property p_pg_in;
    pg_trig && !fault_trig |=> (state_r == ST_OFF_SEQ) && unlock_r && power_good_pin_oe;
  endproperty
  a_pg_in: assert property (p_pg_in) else $error("pg input shutdown wrong");

  property p_fault_hold;
    (state_r == ST_FAULT_OFF) |=> (state_r == ST_FAULT_OFF) && power_good_pin_oe
      && (rail_on == RAILS_NONE);
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault off was left");

  property p_no_quiet_fault;
    (state_r == ST_OFF_SEQ) && (cause_r == CAUSE_FAULT) |=> (state_r != ST_QUIESCENT);
  endproperty
  a_no_quiet_fault: assert property (p_no_quiet_fault) else $error("fault entered quiescent");

  property p_soft_stop;
    entering_off |=> (timer_r == longest_stop(step_r[0][2:0]) - 16'h0001) && !in_delay_r;
  endproperty
  a_soft_stop: assert property (p_soft_stop) else $error("soft-stop wait wrong");

  property p_irq;
    $rose(irq_active) |-> general_status_irq_n_oe ##1 (general_status_irq_n_oe
      || $past(|(event_clear & status_r)) || $past(|(event_mask & status_r)) || $changed(event_mask));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not latched");

  property p_reraise;
    |(event_cond & event_clear) |=> |(status_r & $past(event_cond));
  endproperty
  a_reraise: assert property (p_reraise) else $error("persisting event lost on clear");

  property p_quiet;
    (state_r == ST_QUIESCENT) |-> (rail_on == RAILS_NONE) && !ldo_on && !bus_access_ok;
  endproperty
  a_quiet: assert property (p_quiet) else $error("quiescent outputs wrong");

  property p_pre_enable;
    (state_r == ST_PRE_ENABLE) |-> !reg_en_r[REG_ENABLE_POS] && ldo_on && power_good_pin_oe;
  endproperty
  a_pre_enable: assert property (p_pre_enable) else $error("pre-enable outputs wrong");

  c_quiescent: cover property ((state_r == ST_OFF_SEQ) ##1 (state_r == ST_QUIESCENT));
  c_fault:     cover property ((state_r == ST_OFF_SEQ) ##1 (state_r == ST_FAULT_OFF));
  c_pg_resume: cover property ((state_r == ST_PG_OFF) ##1 (state_r == ST_ON_SEQ));
  c_irq:       cover property ($rose(general_status_irq_n_oe));

endmodule : smpd_ctrl

/* File: dv/smpd_host_model.sv */
`timescale 1ns/1ps
module smpd_host_model (
  input  wire logic pg_oe,
  input  wire logic pg_out,
  input  wire logic pull_low,
  output logic      pg_wire
);
  // pull-up wins unless an end sinks; never floats to x
  assign pg_wire = (pg_oe ? pg_out : 1'b1) & ~pull_low;
endmodule : smpd_host_model

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb;
  import smpd_pkg::*;
  logic clk = 0, rst = 1, sec = 1, pin = 0, pull = 0, bulk = 1, pgw;
  logic [11:0] cond = '0, mask = '0, clr = '0, stat;
  smpd_bus_req_type req = '0;
  logic [7:0] rdata;
  logic pg_oe, irq_oe, acc, ldo, pgo, irqo;
  logic [2:0] rails;
  smpd_state_type st;
  int bad_count = 0, checks = 0, cyc = 0;
  ////////////////////////////////////////////////////////////
  // free running clock
  always #25 clk = ~clk;
  smpd_host_model host (.pg_oe(pg_oe), .pg_out(pgo), .pull_low(pull), .pg_wire(pgw));
  smpd_ctrl dut (.clk(clk), .rst(rst), .secure_mode(sec),
    .bulk_input_supply_valid(bulk), .regulator_enable_pin(pin),
    .power_good_pin_in(pgw), .power_good_pin_out(pgo), .power_good_pin_oe(pg_oe),
    .general_status_irq_n_out(irqo), .general_status_irq_n_oe(irq_oe),
    .event_cond(cond), .event_mask(mask), .event_clear(clr), .event_status(stat),
    .bus_req(req), .bus_rdata(rdata), .bus_access_ok(acc), .rail_on(rails),
    .ldo_on(ldo), .power_state(st));
  ////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // inputs move on falling edges only
  task automatic tick(int n = 1);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic wr(logic [7:0] a, logic [7:0] d);
    req = '{1'h1, 1'h0, a, d};
    tick();
    req = '0;
    tick(); // one idle edge before the next request
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e, string n);
    req = '{1'h0, 1'h1, a, 8'h00};
    tick();
    req = '0;
    chk(n, e, rdata);
    tick();
  endtask : rd
  // bounded wait, sequences run a few hundred cycles
  task automatic wait_st(smpd_state_type s);
    for (int i = 0; i < 1000 && st !== s; i++) tick();
    chk("state", 8'(s), 8'(st));
  endtask : wait_st
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    wait_st(ST_PRE_ENABLE);
    chk("pg_oe", 1, pg_oe);
    rd(ADDR_POWER_OFF_SEQUENCE_STEP2, RST_STEP2, "step2");
    wr(ADDR_RAIL_ENABLE_CONTROL, 8'h00);
    rd(ADDR_RAIL_ENABLE_CONTROL, RST_RAIL_ENABLE, "rail");
    wr(ADDR_REGULATOR_ENABLE_CONTROL, 8'h80);
    tick(2);
    chk("state", 8'(ST_PRE_ENABLE), 8'(st));
    $display("test regs done");
  endtask : t_regs
  // step0 drops rail c only; its 10 soft-stop plus 40 delay holds step1 off
  task automatic t_pin(logic q, smpd_state_type s);
    pin = 1;
    wait_st(ST_REGULATION);
    chk("pg_oe", 0, pg_oe);
    chk("pg_wire", 1, pgw);
    pin = 0;
    tick(5);
    chk("pg_oe", 1, pg_oe);
    chk("pg_wire", 0, pgw);
    chk("rails", 3'h6, rails);
    tick(40);
    chk("rails", 3'h6, rails);
    wait_st(s);
    chk("bus_ok", !q, acc);
    chk("ldo", !q, ldo);
    pin = 1;
    wait_st(ST_REGULATION);
    chk("pg_oe", 0, pg_oe);
    $display("test pin done");
  endtask : t_pin
  task automatic t_pgin;
    sec = 0;
    wr(ADDR_REGULATOR_ENABLE_CONTROL, 8'ha0);
    sec = 1;
    pull = 1;
    wait_st(ST_PG_OFF);
    chk("pg_oe", 1, pg_oe);
    rd(ADDR_QUIESCENT_MODE_CONFIG, 8'h10, "qcfg");
    pull = 0;
    wr(ADDR_REGULATOR_ENABLE_CONTROL, 8'ha0);
    chk("state", 8'(ST_ON_SEQ), 8'(st));
    wait_st(ST_REGULATION);
    wr(ADDR_REGULATOR_ENABLE_CONTROL, 8'h00);
    tick(3);
    chk("state", 8'(ST_REGULATION), 8'(st));
    $display("test pgin done");
  endtask : t_pgin
  task automatic t_irq;
    cond[7] = 1;
    tick(2);
    chk("irq", 1, irq_oe);
    chk("irq_pin", 0, irq_oe ? irqo : 1'b1);
    chk("state", 8'(ST_REGULATION), 8'(st));
    clr[7] = 1;
    tick();
    clr = '0;
    tick();
    chk("irq", 1, irq_oe);
    cond[7] = 0;
    tick(2);
    chk("irq", 1, irq_oe);
    clr[7] = 1;
    tick();
    clr = '0;
    tick();
    chk("irq", 0, irq_oe);
    mask[7] = 1;
    cond[7] = 1;
    tick(2);
    cond[7] = 0;
    chk("stat", 1, stat[7]);
    chk("irq", 0, irq_oe);
    $display("test irq done");
  endtask : t_irq
  task automatic t_fault;
    cond[1] = 1;
    tick();
    cond[1] = 0;
    wait_st(ST_FAULT_OFF);
    pin = 0;
    tick(5);
    pin = 1;
    wr(ADDR_REGULATOR_ENABLE_CONTROL, 8'h80);
    tick(5);
    chk("state", 8'(ST_FAULT_OFF), 8'(st));
    chk("pg_oe", 1, pg_oe);
    $display("test fault done");
  endtask : t_fault
  // mid-run reset stands in for the power cycle, then the bulk supply drops
  task automatic t_reset;
    rst = 1;
    tick(2);
    rst = 0;
    tick();
    chk("state", 8'(ST_INVALID_INPUT), 8'(st));
    chk("ldo", 0, ldo);
    wait_st(ST_PRE_ENABLE);
    rd(ADDR_QUIESCENT_MODE_CONFIG, RST_QUIESCENT_CONFIG, "qcfg");
    bulk = 0;
    tick(4);
    chk("state", 8'(ST_INVALID_INPUT), 8'(st));
    chk("bus_ok", 0, acc);
    bulk = 1;
    wait_st(ST_PRE_ENABLE);
    $display("test reset done");
  endtask : t_reset
  ////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // hang guard, the tests need a few thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end
  // main sequence; config writes need secure mode off
  initial begin
    tick(4);
    rst = 0;
    t_regs();
    t_pin(0, ST_PIN_OFF);
    sec = 0;
    wr(ADDR_QUIESCENT_MODE_CONFIG, 8'h10);
    sec = 1;
    t_pin(1, ST_QUIESCENT);
    t_pgin();
    t_irq();
    t_fault();
    t_reset();
    results();
  end
endmodule : tb
